/* common/arinc_tx_pkg.sv */
// Shared constants and types for the ARINC 429 transmit and label control block.
// Assumes a 100 MHz system clock; the 1 MHz data clock is derived as an enable.
package arinc_tx_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned DATA_CLK_HZ   = 1_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_DIV      = CLK_HZ / DATA_CLK_HZ;
  localparam logic [6:0]  TICK_LAST     = 7'(TICK_DIV - 1);
  // Longest wait from enable to first bit, 2.5 data clocks
  localparam int unsigned FIRST_BIT_NS  = 2500;
  localparam int unsigned FIRST_BIT_CYC = FIRST_BIT_NS / CLK_PERIOD_NS;

  // Half-bit and word-gap lengths in data clocks
  localparam logic [8:0] HALF_HI = 9'h005;
  localparam logic [8:0] HALF_LO = 9'h028;
  localparam logic [8:0] GAP_HI  = 9'h028;
  localparam logic [8:0] GAP_LO  = 9'h140;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam logic [5:0] FIFO_DEPTH   = 6'h20;
  localparam logic [5:0] HALF_MARK    = 6'h10;
  localparam logic [4:0] LABEL_COUNT  = 5'h10;
  localparam logic [4:0] LAST_BIT_IDX = 5'h1f;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TX_LO  = 8'h04;
  localparam logic [7:0] ADDR_TX_HI  = 8'h08;
  localparam logic [7:0] ADDR_RX1_LO = 8'h0c;
  localparam logic [7:0] ADDR_RX1_HI = 8'h10;
  localparam logic [7:0] ADDR_RX2_LO = 8'h14;
  localparam logic [7:0] ADDR_RX2_HI = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_LABEL_ACCESS = 1;
  localparam int unsigned CTRL_FILTER_RX1   = 2;
  localparam int unsigned CTRL_FILTER_RX2   = 3;
  localparam int unsigned CTRL_PARITY_EN    = 4;
  localparam int unsigned CTRL_SELF_TEST    = 5;
  localparam int unsigned CTRL_PARITY_SEL   = 12;
  localparam int unsigned CTRL_RATE_SEL     = 13;
  localparam int unsigned CTRL_BYTE_ORDER   = 15;
  localparam logic [15:0] CTRL_RESET        = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } rx_word_type;

  typedef struct packed {
    logic pos;
    logic neg;
  } line_sym_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_DATA = 4'h2,
    ST_NULL = 4'h4,
    ST_GAP  = 4'h8
  } tx_state_type;

endpackage

/* logic/arinc_tx_label_control.sv */
// ARINC 429 transmit path, label memory and receive FIFOs behind a Wishbone slave.
// Assumes decoded received words arrive from external bit samplers as one-cycle
// valid pulses, and that all pins are synchronous to mclk.
//
// Summary of operation
// - Filtering on: unmatched received words leave no trace
// - Label is bits 1-8; zero is ordinary
// - Sixteen load strobes after access rise write labels
// - Reception suspended during label memory access
// - Sixteen read strobes after access rise return labels
// - Strobe one low half, strobe two stores word
// - Thirty-two words; full flag; further loads ignored
// - Half flag high below sixteen words
// - Ready flag high when all words sent
// - Parity bit odd or even, or data
// - Enable loads head word; first bit quickly
// - Bit is data half then equal null half
// - Null word gap of 40 or 320 clocks
// - Rate select: 100 or 12.5 kbit/s
// - Self test loops output to both receivers
// - Test input forces line outputs null
// - Full receive FIFO overwrites newest word
// - Master reset clears FIFOs, flags; control kept
// - Words failing enabled checks are discarded
`timescale 1ns/1ns

module arinc_tx_label_control
  import arinc_tx_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Wishbone slave
  input  wire logic         cyc_i,
  input  wire logic         stb_i,
  input  wire logic         we_i,
  input  wire logic [7:0]   adr_i,
  input  wire logic [3:0]   sel_i,
  input  wire logic [31:0]  dat_i,
  output logic [31:0]       dat_o,
  output logic              ack_o,
  // Device pins
  input  wire logic         masterResetInput,
  input  wire logic         transmitEnable,
  input  wire logic         testInput,
  // Decoded words from the two receivers
  input  wire rx_word_type  rxIn1,
  input  wire rx_word_type  rxIn2,
  // Line outputs and internal loopback
  output logic              lineOutPos,
  output logic              lineOutNeg,
  output line_sym_type      loopRx1,
  output line_sym_type      loopRx2,
  // Flags
  output logic              txFifoFullFlag,
  output logic              txFifoHalfFlag,
  output logic              txReady,
  output logic [1:0]        rxDataReady
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic labelHit(input logic [15:0][7:0] tab, input logic [7:0] lab);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (tab[i] == lab) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic [31:0] addParity(input logic [31:0] w, input logic en,
                                            input logic evenSel);
    logic [31:0] o;
    o = w;
    if (en) begin
      o[31] = evenSel ? ^w[30:0] : ~^w[30:0];
    end
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0]        ctrl_r;
  logic               req;
  logic               wrReq;
  logic               rdReq;
  logic               hitCtrl;
  logic               hitTxLo;
  logic               hitTxHi;
  logic               hitStatus;
  logic [1:0]         hitRxLo;
  logic [1:0]         hitRxHi;
  logic               loadOne;
  logic               loadTwo;
  logic               ctrlRise;
  logic               labelAccess;
  logic [1:0]         filterEn;
  logic [15:0][7:0]   labelMem_r [2];
  logic [4:0]         labelCnt_r [2];
  logic [1:0]         labelWr;
  logic [1:0]         labelRd;
  logic [31:0]        rxMem_r [2][32];
  logic [4:0]         rxWr_r [2];
  logic [4:0]         rxRd_r [2];
  logic [5:0]         rxCount_r [2];
  rx_word_type        rxIn [2];
  logic [1:0]         rxPush;
  logic [1:0]         rxPop;
  logic [1:0]         rxFull;
  logic [31:0]        txMem_r [32];
  logic [4:0]         txWr_r;
  logic [4:0]         txRd_r;
  logic [5:0]         txCount_r;
  logic [15:0]        loHalf_r;
  logic               txPush;
  logic               txPop;
  tx_state_type       state_r;
  logic [6:0]         tickCnt_r;
  logic               tick;
  logic [8:0]         phase_r;
  logic [4:0]         bitIdx_r;
  logic [31:0]        shift_r;
  logic [8:0]         halfLast;
  logic [8:0]         gapLast;
  logic [15:0]        statusWord;

  assign labelAccess = ctrl_r[CTRL_LABEL_ACCESS];
  assign filterEn    = {ctrl_r[CTRL_FILTER_RX2], ctrl_r[CTRL_FILTER_RX1]};
  assign rxIn[0]     = rxIn1;
  assign rxIn[1]     = rxIn2;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Every access is answered one cycle after it is seen, unmapped ones too
  assign req   = cyc_i & stb_i & ~ack_o;
  assign wrReq = req & we_i;
  assign rdReq = req & ~we_i;

  always_comb begin
    hitCtrl   = 1'b0;
    hitTxLo   = 1'b0;
    hitTxHi   = 1'b0;
    hitStatus = 1'b0;
    hitRxLo   = 2'b00;
    hitRxHi   = 2'b00;
    if (adr_i == ADDR_CTRL) begin
      hitCtrl = 1'b1;
    end else if (adr_i == ADDR_TX_LO) begin
      hitTxLo = 1'b1;
    end else if (adr_i == ADDR_TX_HI) begin
      hitTxHi = 1'b1;
    end else if (adr_i == ADDR_RX1_LO) begin
      hitRxLo[0] = 1'b1;
    end else if (adr_i == ADDR_RX1_HI) begin
      hitRxHi[0] = 1'b1;
    end else if (adr_i == ADDR_RX2_LO) begin
      hitRxLo[1] = 1'b1;
    end else if (adr_i == ADDR_RX2_HI) begin
      hitRxHi[1] = 1'b1;
    end else if (adr_i == ADDR_STATUS) begin
      hitStatus = 1'b1;
    end
  end

  assign loadOne  = wrReq & hitTxLo;
  assign loadTwo  = wrReq & hitTxHi;
  assign ctrlRise = wrReq & hitCtrl & sel_i[0] & dat_i[CTRL_LABEL_ACCESS] & ~labelAccess;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // Control register survives master reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET;
    end else if (wrReq && hitCtrl) begin
      if (sel_i[0]) begin
        ctrl_r[7:0] <= dat_i[7:0];
      end
      if (sel_i[1]) begin
        ctrl_r[15:8] <= dat_i[15:8];
      end
    end
  end

  assign statusWord = {7'h00, txFifoFullFlag, txFifoHalfFlag, txReady,
                       rxFull[1], rxCount_r[1] >= HALF_MARK, rxDataReady[1],
                       rxFull[0], rxCount_r[0] >= HALF_MARK, rxDataReady[0]};

  always_ff @(posedge mclk) begin
    if (rst) begin
      dat_o <= 32'h0000_0000;
    end else if (rdReq) begin
      dat_o <= 32'h0000_0000;
      if (hitCtrl) begin
        dat_o <= {16'h0000, ctrl_r};
      end else if (hitStatus) begin
        dat_o <= {16'h0000, statusWord};
      end else begin
        for (int r = 0; r < 2; r++) begin
          if (hitRxLo[r]) begin
            dat_o <= {16'h0000, rxMem_r[r][rxRd_r[r]][15:0]};
          end else if (hitRxHi[r] && labelRd[r]) begin
            dat_o <= {24'h00_0000, labelMem_r[r][labelCnt_r[r][3:0]]};
          end else if (hitRxHi[r] && !labelAccess) begin
            dat_o <= {16'h0000, rxMem_r[r][rxRd_r[r]][31:16]};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Label memory
  // ----------------------------------------------------------------
  // Selector-high reads are the label reads
  always_comb begin
    for (int r = 0; r < 2; r++) begin
      labelWr[r] = labelAccess && (labelCnt_r[r] < LABEL_COUNT) && (r == 0 ? loadOne : loadTwo);
      labelRd[r] = labelAccess && (labelCnt_r[r] < LABEL_COUNT) && rdReq && hitRxHi[r];
    end
  end

  always_ff @(posedge mclk) begin
    for (int r = 0; r < 2; r++) begin
      if (rst || ctrlRise) begin
        labelCnt_r[r] <= 5'h00;
      end else if (labelWr[r] || labelRd[r]) begin
        labelCnt_r[r] <= labelCnt_r[r] + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    for (int r = 0; r < 2; r++) begin
      if (labelWr[r]) begin
        labelMem_r[r][labelCnt_r[r][3:0]] <= dat_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive FIFOs
  // ----------------------------------------------------------------
  always_comb begin
    for (int r = 0; r < 2; r++) begin
      rxPush[r] = rxIn[r].valid && !labelAccess && !masterResetInput &&
                  (!filterEn[r] || labelHit(labelMem_r[r], rxIn[r].data[7:0]));
      rxPop[r]  = rdReq && hitRxHi[r] && !labelAccess && (rxCount_r[r] != 6'h00);
      rxFull[r] = rxCount_r[r] == FIFO_DEPTH;
    end
  end

  assign rxDataReady = {rxCount_r[1] != 6'h00, rxCount_r[0] != 6'h00};

  always_ff @(posedge mclk) begin
    for (int r = 0; r < 2; r++) begin
      if (rst || masterResetInput) begin
        rxWr_r[r]    <= 5'h00;
        rxRd_r[r]    <= 5'h00;
        rxCount_r[r] <= 6'h00;
      end else begin
        if (rxPop[r]) begin
          rxRd_r[r] <= rxRd_r[r] + 5'h01;
        end
        if (rxPush[r] && (!rxFull[r] || rxPop[r])) begin
          rxWr_r[r] <= rxWr_r[r] + 5'h01;
        end
        if (rxPush[r] && (!rxFull[r] || rxPop[r]) && !rxPop[r]) begin
          rxCount_r[r] <= rxCount_r[r] + 6'h01;
        end else if (rxPop[r] && !rxPush[r]) begin
          rxCount_r[r] <= rxCount_r[r] - 6'h01;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    for (int r = 0; r < 2; r++) begin
      if (rxPush[r]) begin
        if (rxFull[r] && !rxPop[r]) begin
          rxMem_r[r][rxWr_r[r] - 5'h01] <= rxIn[r].data;
        end else begin
          rxMem_r[r][rxWr_r[r]] <= rxIn[r].data;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------
  // full FIFO refuses loads
  assign txPush = loadTwo && !labelAccess && !masterResetInput && (txCount_r != FIFO_DEPTH);
  assign txPop  = (state_r == ST_IDLE) && transmitEnable && !masterResetInput &&
                  (txCount_r != 6'h00);

  assign txFifoFullFlag = txCount_r == FIFO_DEPTH;
  assign txFifoHalfFlag = txCount_r < HALF_MARK;
  assign txReady        = (txCount_r == 6'h00) && (state_r == ST_IDLE);

  always_ff @(posedge mclk) begin
    if (rst || masterResetInput) begin
      loHalf_r <= 16'h0000;
    end else if (loadOne && !labelAccess) begin
      loHalf_r <= dat_i[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || masterResetInput) begin
      txWr_r    <= 5'h00;
      txRd_r    <= 5'h00;
      txCount_r <= 6'h00;
    end else begin
      if (txPush) begin
        txWr_r <= txWr_r + 5'h01;
      end
      if (txPop) begin
        txRd_r <= txRd_r + 5'h01;
      end
      if (txPush && !txPop) begin
        txCount_r <= txCount_r + 6'h01;
      end else if (txPop && !txPush) begin
        txCount_r <= txCount_r - 6'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (txPush) begin
      txMem_r[txWr_r] <= {dat_i[15:0], loHalf_r};
    end
  end

  // ----------------------------------------------------------------
  // Serialiser
  // ----------------------------------------------------------------
  // rate select picks bit lengths
  assign halfLast = (ctrl_r[CTRL_RATE_SEL] ? HALF_LO : HALF_HI) - 9'h001;
  assign gapLast  = (ctrl_r[CTRL_RATE_SEL] ? GAP_LO : GAP_HI) - 9'h001;
  assign tick     = tickCnt_r == TICK_LAST;

  // Divider restarts on each word so that every half is exact
  always_ff @(posedge mclk) begin
    if (rst || txPop || tick) begin
      tickCnt_r <= 7'h00;
    end else begin
      tickCnt_r <= tickCnt_r + 7'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || masterResetInput) begin
      state_r  <= ST_IDLE;
      phase_r  <= 9'h000;
      bitIdx_r <= 5'h00;
      shift_r  <= 32'h0000_0000;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (txPop) begin
            shift_r  <= addParity(txMem_r[txRd_r], ctrl_r[CTRL_PARITY_EN],
                                  ctrl_r[CTRL_PARITY_SEL]);
            phase_r  <= 9'h000;
            bitIdx_r <= 5'h00;
            state_r  <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tick) begin
            if (phase_r == halfLast) begin
              phase_r <= 9'h000;
              state_r <= ST_NULL;
            end else begin
              phase_r <= phase_r + 9'h001;
            end
          end
        end
        ST_NULL: begin
          if (tick) begin
            if (phase_r == halfLast) begin
              phase_r <= 9'h000;
              shift_r <= {1'b0, shift_r[31:1]};
              if (bitIdx_r == LAST_BIT_IDX) begin
                state_r <= ST_GAP;
              end else begin
                bitIdx_r <= bitIdx_r + 5'h01;
                state_r  <= ST_DATA;
              end
            end else begin
              phase_r <= phase_r + 9'h001;
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            if (phase_r == gapLast) begin
              phase_r <= 9'h000;
              state_r <= ST_IDLE;
            end else begin
              phase_r <= phase_r + 9'h001;
            end
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Line symbols and loopback
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst || masterResetInput) begin
      lineOutPos <= 1'b0;
      lineOutNeg <= 1'b0;
      loopRx1    <= '0;
      loopRx2    <= '0;
    end else begin
      // pos for one, neg for zero
      lineOutPos <= (state_r == ST_DATA) && shift_r[0] && !testInput;
      lineOutNeg <= (state_r == ST_DATA) && !shift_r[0] && !testInput;
      loopRx1.pos <= !ctrl_r[CTRL_SELF_TEST] && (state_r == ST_DATA) && shift_r[0];
      loopRx1.neg <= !ctrl_r[CTRL_SELF_TEST] && (state_r == ST_DATA) && !shift_r[0];
      loopRx2.pos <= !ctrl_r[CTRL_SELF_TEST] && (state_r == ST_DATA) && !shift_r[0];
      loopRx2.neg <= !ctrl_r[CTRL_SELF_TEST] && (state_r == ST_DATA) && shift_r[0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int FirstBitWin = FIRST_BIT_CYC;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_TX_FULL_IGNORE: assert property (
    (loadTwo && txCount_r == FIFO_DEPTH && !txPop && !masterResetInput)
      |=> txCount_r == FIFO_DEPTH)
    else $error("load into full transmit FIFO was taken");

  AST_TX_HALF_FLAG: assert property (
    txFifoHalfFlag == (txCount_r <= 6'h0f))
    else $error("half flag disagrees with word count");

  AST_TX_READY: assert property (
    txReady |-> (txCount_r == 6'h00 && !lineOutPos && !lineOutNeg) ##1 !$past(txPop))
    else $error("ready flag high with words pending");

  AST_DATA_HALF_END: assert property (
    (state_r == ST_DATA && tick && phase_r == halfLast && !masterResetInput)
      |=> state_r == ST_NULL ##1 (!lineOutPos && !lineOutNeg))
    else $error("data half did not end in null half");

  AST_WORD_GAP: assert property (
    (state_r == ST_NULL && tick && phase_r == halfLast && bitIdx_r == LAST_BIT_IDX &&
     !masterResetInput) |=> state_r == ST_GAP ##1 (!lineOutPos && !lineOutNeg))
    else $error("word gap not entered after last bit");

  AST_TEST_NULL: assert property (
    testInput |=> (!lineOutPos && !lineOutNeg))
    else $error("line driven while test input high");

  AST_SYMBOL_LEGAL: assert property (
    !(lineOutPos && lineOutNeg))
    else $error("both line outputs asserted");

  AST_LOOPBACK: assert property (
    (!ctrl_r[CTRL_SELF_TEST] && !testInput && !masterResetInput)
      |=> (loopRx1 == {lineOutPos, lineOutNeg} && loopRx2 == {lineOutNeg, lineOutPos}))
    else $error("receiver two loopback not inverted");

  AST_FIRST_BIT: assert property (
    (txPop && !testInput) |-> ##[1:FirstBitWin] (lineOutPos || lineOutNeg || testInput))
    else $error("first bit late after transmit enable");

  AST_RX_SUSPEND: assert property (
    labelAccess |=> $stable(rxWr_r[0]) && $stable(rxWr_r[1]))
    else $error("word received during label access");

  AST_MASTER_RESET: assert property (
    (masterResetInput && !(wrReq && hitCtrl)) |=> (txCount_r == 6'h00 && rxCount_r[0] == 6'h00 &&
                          rxCount_r[1] == 6'h00 && ctrl_r == $past(ctrl_r)))
    else $error("master reset did not clear FIFOs or touched control");

endmodule

/* tb/host_model.sv */
// Wishbone classic master standing in for the host processor.
// Assumes a slave that acks each request once; the bench bounds any hang.
`timescale 1ns/1ns

module host_model (
  // Clock and answer
  input  wire logic        mclk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  // Request
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we  = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
  end

  // ------------------------------------------------------------
  // Single cycle
  // ------------------------------------------------------------
  // Released data is inverted so a stale value never passes
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    dat <= ~d;
  endtask
endmodule

/* tb/arinc_tx_label_control_bench.sv */
// Self-checking bench for the transmit and label control block.
// Assumes the host model for bus cycles; receiver words driven here.
`timescale 1ns/1ns

module arinc_tx_label_control_bench;
  import arinc_tx_pkg::*;
  logic mclk, rst, mr, txEn, tst, ack, full, half, rdy;
  logic cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic pos, neg;
  logic [1:0] rxRdy;
  rx_word_type rx1, rx2;
  line_sym_type lp1, lp2;
  int num_errors = 0;
  int checks = 0;
  int ticks = 0;

  host_model i_host (.mclk(mclk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat(wdat));
  arinc_tx_label_control i_dut (.mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .masterResetInput(mr), .transmitEnable(txEn), .testInput(tst), .rxIn1(rx1),
    .rxIn2(rx2), .lineOutPos(pos), .lineOutNeg(neg), .loopRx1(lp1), .loopRx2(lp2),
    .txFifoFullFlag(full), .txFifoHalfFlag(half), .txReady(rdy), .rxDataReady(rxRdy));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic push(input logic r, input logic [31:0] d);
    @(posedge mclk);
    if (r) begin
      rx2 <= '{1'b1, d};
    end else begin
      rx1 <= '{1'b1, d};
    end
    @(posedge mclk);
    rx1.valid <= 1'b0;
    rx2.valid <= 1'b0;
    cyc_wait(2);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_fill();
    wr(ADDR_CTRL, 32'h10);
    for (int i = 0; i < 33; i++) begin
      if (i == 15 || i == 16) chk(half, i == 15);
      wr(ADDR_TX_LO, i);
      wr(ADDR_TX_HI, 32'h0);
    end
    rd(ADDR_STATUS, 32'h100);
    @(posedge mclk);
    mr <= 1'b1;
    @(posedge mclk);
    mr <= 1'b0;
    cyc_wait(1);
    chk({full, half, rdy}, 3'b011);
    rd(ADDR_CTRL, 32'h10);
  endtask

  task automatic t_labels();
    wr(ADDR_CTRL, 32'h12);
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_TX_LO, i);
      wr(ADDR_TX_HI, 32'h80 | i);
    end
    push(1'b0, 32'h0);
    chk(rxRdy, 2'b00);
    wr(ADDR_CTRL, 32'h10);
    wr(ADDR_CTRL, 32'h12);
    for (int i = 0; i < 16; i++) begin
      rd(ADDR_RX1_HI, i);
      rd(ADDR_RX2_HI, 32'h80 | i);
    end
    wr(ADDR_CTRL, 32'h10);
    wr(ADDR_CTRL, 32'h1c);
    push(1'b0, 32'h20);
    push(1'b1, 32'h20);
    chk(rxRdy, 2'b00);
    push(1'b0, 32'habcd_0000);
    push(1'b1, 32'h1234_0085);
    chk(rxRdy, 2'b11);
    rd(ADDR_RX1_LO, 32'h0);
    rd(ADDR_RX1_HI, 32'habcd);
    rd(ADDR_RX2_LO, 32'h85);
    rd(ADDR_RX2_HI, 32'h1234);
    rd(8'h40, 32'h0);
    wr(ADDR_CTRL, 32'h10);
    for (int i = 0; i < 33; i++) begin
      push(1'b0, i);
    end
    rd(ADDR_STATUS, 32'h0c7);
    for (int i = 0; i < 31; i++) begin
      rd(ADDR_RX1_HI, 32'h0);
    end
    rd(ADDR_RX1_LO, 32'h20);
    rd(ADDR_RX1_HI, 32'h0);
  endtask

  task automatic t_send();
    int n;
    wr(ADDR_TX_LO, 32'h1);
    wr(ADDR_TX_HI, 32'h8000);
    @(posedge mclk);
    txEn <= 1'b1;
    n = 0;
    while (pos !== 1'b1 && n < FIRST_BIT_CYC) begin
      cyc_wait(1);
      n++;
    end
    chk(pos, 1'b1);
    cyc_wait(490);
    chk({pos, neg}, 2'b10);
    chk({lp1, lp2}, 4'b1001);
    cyc_wait(20);
    chk({pos, neg}, 2'b00);
    cyc_wait(740);
    chk({pos, neg}, 2'b01);
    @(posedge mclk);
    tst <= 1'b1;
    cyc_wait(2);
    chk({pos, neg}, 2'b00);
    chk({lp1, lp2}, 4'b0110);
    @(posedge mclk);
    tst <= 1'b0;
    cyc_wait(29996);
    chk({pos, neg}, 2'b01);
    cyc_wait(4650);
    chk(rdy, 1'b0);
    cyc_wait(200);
    chk(rdy, 1'b1);
    // Slow rate with self test off; master reset cuts the word short
    wr(ADDR_CTRL, 32'h2030);
    wr(ADDR_TX_LO, 32'h1);
    wr(ADDR_TX_HI, 32'h0);
    cyc_wait(3900);
    chk({pos, neg}, 2'b10);
    chk({lp1, lp2}, 4'b0000);
    cyc_wait(200);
    chk({pos, neg}, 2'b00);
    @(posedge mclk);
    mr <= 1'b1;
    @(posedge mclk);
    mr <= 1'b0;
    cyc_wait(1);
    chk({pos, neg, rdy}, 3'b001);
  endtask

  // ------------------------------------------------------------
  // Main sequence and timeout
  // ------------------------------------------------------------
  always @(posedge mclk) begin
    ticks++;
    if (ticks == 60000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    rst = 1'b1;
    mr = 1'b0;
    txEn = 1'b0;
    tst = 1'b0;
    rx1 = '0;
    rx2 = '0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    cyc_wait(1);
    chk({full, half, rdy}, 3'b011);
    t_fill();
    t_labels();
    t_send();
    close_out();
  end
endmodule
